// *** head_stepper_defines.vh ***
/*
  Constants for the head stepper and track control block: timing figures,
  clock rate, track limits and the APB register map with its fields.
  Assumes it is included by its bare name from the design file.
*/
`ifndef HEAD_STEPPER_DEFINES_VH
`define HEAD_STEPPER_DEFINES_VH

// ==========================================================
// clock and timing figures (microseconds)
`define CLK_MHZ 40
`define STEP_DELAY_US 3000
`define OVERLAP_US 600
`define OVERDRIVE_US 50000
`define RECAL_MAX_US 255000
// same figures as clock counts at 40 MHz
`define STEP_DELAY_CYC_DEF 24'h01D4C0
`define OVERLAP_CYC_DEF 24'h005DC0
`define OVERDRIVE_CYC_DEF 24'h1E8480
`define RECAL_MAX_CYC_DEF 24'h9BA3C0

// ==========================================================
// track counter limits
`define OUTER_ZONE_LAST 7'h2B
`define TRACK_LAST 7'h4F

// ==========================================================
// register map (byte addresses)
`define ADDR_W 12
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004

// control fields
`define CTRL_RECAL_BIT 0
`define CTRL_BLOCK_BIT 1
`define CTRL_RESET 2'h0

// status fields
`define ST_TRACK_LSB 0
`define ST_DIR_BIT 8
`define ST_RECAL_BIT 9
`define ST_TIMEOUT_BIT 10
`define ST_CHANGED_BIT 11
`define ST_POS_LSB 12
`define ST_OVERDRIVE_BIT 14
`define ST_TZERO_BIT 15

`endif

// *** head_stepper_track_control.v ***
/*
  Head positioning logic: direction latch, internal and recalibration step
  generation, 1-2 phase stepper sequencing, overdrive timer, track counter,
  disk-change flip-flop and drive-select gating of host outputs, with an
  APB slave for control and status.
  Assumes all inputs are synchronous to pclk and that the host keeps step
  pulses at least two clocks high and two clocks low.
*/
// Chosen here: register access over APB and the register offsets.
// Functional notes
// - each host step captures seek direction; direction sets phase order; code ignores steps during recalibration or while the block bit is set
// - density low: second internal step about 3 ms after host step
// - density high one step per host step, low two steps
// - auto-home enabled: recal steps every 3 ms after supply rises
// - recalibration ends within 255 ms of its start
// - during recalibration ready is low and host steps are ignored
// - steps and direction drive four phases in 1-2 phase mode
// - each phase change overlaps old and new phase for 0.6 ms
// - every step retriggers 50 ms overdrive timer, output low while running
// - track zero out needs sensor high, step-out and phase A high
// - track counter cleared on track zero, counts up on step-in
// - outer zone flag high for tracks 0-43, low for 44-79
// - low supply sense holds all internal logic in reset except input edge, host output and APB registers
// - polarity input inverts host outputs; high means true is high
// - disk removal sets disk-change flip-flop, changed output high
// - clear strobe with disk present and drive selected clears change
// - host outputs valid only while drive select is low
// - option gates index and read data with ready
`include "head_stepper_defines.vh"

module head_stepper_track_control #(
  parameter [23:0] STEP_DELAY_CYC = `STEP_DELAY_CYC_DEF,
  parameter [23:0] OVERLAP_CYC = `OVERLAP_CYC_DEF,
  parameter [23:0] OVERDRIVE_CYC = `OVERDRIVE_CYC_DEF,
  parameter [23:0] RECAL_MAX_CYC = `RECAL_MAX_CYC_DEF,
  parameter GATE_WITH_READY = 0
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // host interface inputs
  input wire host_step_pulse,
  input wire seek_direction_in,
  input wire drive_select_n,
  input wire change_clear_strobe,
  // straps and sensors
  input wire density_select,
  input wire auto_home_enable_n,
  input wire low_voltage_ok,
  input wire output_polarity_invert,
  input wire track_zero_sensor,
  input wire disk_present,
  input wire spindle_ready,
  input wire index_in,
  input wire read_data_in,
  // stepper phases and overdrive
  output reg phase_a_drive,
  output reg phase_b_drive,
  output reg phase_a_bar_drive,
  output reg phase_b_bar_drive,
  output reg stepper_overdrive_n,
  // track and host outputs
  output reg outer_zone_flag,
  output reg track_zero_out,
  output reg disk_changed_out,
  output reg drive_ready_out,
  output reg index_out,
  output reg read_data_out
);

  // one-hot phase pattern for a position
  function [3:0] phase_of;
    input [1:0] pos;
    begin
      phase_of = 4'h1 << pos;
    end
  endfunction

  // host pin level from truth, select and polarity
  function host_level;
    input truth;
    input en;
    input inv;
    begin
      host_level = ~((truth & en) ^ inv);
    end
  endfunction

  // ==========================================================
  // input edges and supply reset
  reg step_prev_q;
  reg clr_prev_q;
  reg lvs_prev_q;
  wire lv_rst = ~low_voltage_ok;
  wire host_edge = host_step_pulse & ~step_prev_q;
  wire clr_edge = change_clear_strobe & ~clr_prev_q;
  wire lvs_rise = low_voltage_ok & ~lvs_prev_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_prev_q <= 1'b0;
      clr_prev_q <= 1'b0;
      lvs_prev_q <= 1'b0;
    end else begin
      step_prev_q <= host_step_pulse;
      clr_prev_q <= change_clear_strobe;
      lvs_prev_q <= low_voltage_ok;
    end
  end

  // ==========================================================
  // control register and step sources
  reg [1:0] ctrl_q;
  reg recal_q;
  reg recal_to_q;
  reg [23:0] recal_tmr_q;
  reg [23:0] recal_tot_q;
  reg istep_pend_q;
  reg [23:0] istep_cnt_q;
  reg dir_in_q;
  reg tz_q;
  wire apb_wr = psel & penable & pready & pwrite & ~pslverr;
  wire ctrl_wr = apb_wr & (paddr == `REG_CTRL);
  wire soft_recal = ctrl_wr & pwdata[`CTRL_RECAL_BIT];
  wire host_take = host_edge & ~recal_q & ~ctrl_q[`CTRL_BLOCK_BIT];
  wire istep_fire = istep_pend_q & (istep_cnt_q == 24'h000000);
  wire recal_fire = recal_q & ~tz_q & (recal_tmr_q == 24'h000000);
  wire step_ev = host_take | istep_fire | recal_fire;
  wire step_dir = host_take ? seek_direction_in : dir_in_q;
  wire recal_start = (lvs_rise & ~auto_home_enable_n) | soft_recal;

  // control register: block bit held, recal bit is a command
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `CTRL_RESET;
    end else if (lv_rst) begin
      ctrl_q <= `CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_q <= {pwdata[`CTRL_BLOCK_BIT], 1'b0};
    end
  end

  // direction latch, step-out forced during recalibration
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_in_q <= 1'b0;
    end else if (lv_rst) begin
      dir_in_q <= 1'b0;
    end else if (recal_start) begin
      dir_in_q <= 1'b0;
    end else if (host_take) begin
      dir_in_q <= seek_direction_in;
    end
  end

  // internal second step while density select is low
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istep_pend_q <= 1'b0;
      istep_cnt_q <= 24'h000000;
    end else if (lv_rst || recal_q) begin
      istep_pend_q <= 1'b0;
      istep_cnt_q <= 24'h000000;
    end else if (host_take) begin
      istep_pend_q <= ~density_select;
      istep_cnt_q <= STEP_DELAY_CYC - 24'h000002;
    end else if (istep_fire) begin
      istep_pend_q <= 1'b0;
    end else if (istep_pend_q) begin
      istep_cnt_q <= istep_cnt_q - 24'h000001;
    end
  end

  // recalibration: step every 3 ms until qualified track zero or 255 ms
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      recal_q <= 1'b0;
      recal_to_q <= 1'b0;
      recal_tmr_q <= 24'h000000;
      recal_tot_q <= 24'h000000;
    end else if (lv_rst) begin
      recal_q <= 1'b0;
      recal_to_q <= 1'b0;
      recal_tmr_q <= 24'h000000;
      recal_tot_q <= 24'h000000;
    end else if (recal_start) begin
      recal_q <= 1'b1;
      recal_to_q <= 1'b0;
      recal_tmr_q <= 24'h000000;
      recal_tot_q <= RECAL_MAX_CYC - 24'h000001;
    end else if (recal_q) begin
      if (tz_q) begin
        recal_q <= 1'b0;
      end else if (recal_tot_q == 24'h000000) begin
        recal_q <= 1'b0;
        recal_to_q <= 1'b1;
      end else begin
        recal_tot_q <= recal_tot_q - 24'h000001;
        recal_tmr_q <= recal_fire ? STEP_DELAY_CYC - 24'h000001 :
          recal_tmr_q - 24'h000001;
      end
    end
  end

  // ==========================================================
  // phase sequencer with overlap period
  reg [1:0] pos_q;
  reg [1:0] prev_pos_q;
  reg [23:0] ovl_cnt_q;
  wire [1:0] pos_d = step_dir ? pos_q + 2'h1 : pos_q - 2'h1;
  wire [3:0] phase_d = phase_of(pos_q) |
    ((ovl_cnt_q != 24'h000000) ? phase_of(prev_pos_q) : 4'h0);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_q <= 2'h0;
      prev_pos_q <= 2'h0;
      ovl_cnt_q <= 24'h000000;
    end else if (lv_rst) begin
      pos_q <= 2'h0;
      prev_pos_q <= 2'h0;
      ovl_cnt_q <= 24'h000000;
    end else if (step_ev) begin
      prev_pos_q <= pos_q;
      pos_q <= pos_d;
      ovl_cnt_q <= OVERLAP_CYC;
    end else if (ovl_cnt_q != 24'h000000) begin
      ovl_cnt_q <= ovl_cnt_q - 24'h000001;
    end
  end

  // phase outputs registered
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {phase_b_bar_drive, phase_a_bar_drive, phase_b_drive, phase_a_drive} <= 4'h1;
    end else if (lv_rst) begin
      {phase_b_bar_drive, phase_a_bar_drive, phase_b_drive, phase_a_drive} <= 4'h1;
    end else begin
      {phase_b_bar_drive, phase_a_bar_drive, phase_b_drive, phase_a_drive} <= phase_d;
    end
  end

  // ==========================================================
  // overdrive timer, retriggered by every step
  reg [23:0] od_cnt_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      od_cnt_q <= 24'h000000;
      stepper_overdrive_n <= 1'b1;
    end else if (lv_rst) begin
      od_cnt_q <= 24'h000000;
      stepper_overdrive_n <= 1'b1;
    end else begin
      if (step_ev) begin
        od_cnt_q <= OVERDRIVE_CYC;
      end else if (od_cnt_q != 24'h000000) begin
        od_cnt_q <= od_cnt_q - 24'h000001;
      end
      stepper_overdrive_n <= ~(step_ev | (od_cnt_q > 24'h000001));
    end
  end

  // ==========================================================
  // track zero qualification, track counter, outer zone
  reg [6:0] trk_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tz_q <= 1'b0;
      trk_q <= 7'h00;
      outer_zone_flag <= 1'b1;
    end else if (lv_rst) begin
      tz_q <= 1'b0;
      trk_q <= 7'h00;
      outer_zone_flag <= 1'b1;
    end else begin
      tz_q <= track_zero_sensor & ~dir_in_q & phase_a_drive;
      if (tz_q) begin
        trk_q <= 7'h00;
      end else if (step_ev && step_dir && trk_q != `TRACK_LAST) begin
        trk_q <= trk_q + 7'h01;
      end else if (step_ev && !step_dir && trk_q != 7'h00) begin
        trk_q <= trk_q - 7'h01;
      end
      outer_zone_flag <= (trk_q <= `OUTER_ZONE_LAST);
    end
  end

  // ==========================================================
  // disk-change flip-flop, set wins over clear
  reg dc_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dc_q <= 1'b0;
    end else if (lv_rst) begin
      dc_q <= 1'b0;
    end else if (!disk_present) begin
      dc_q <= 1'b1;
    end else if (clr_edge && !drive_select_n) begin
      dc_q <= 1'b0;
    end
  end

  // ==========================================================
  // host outputs gated by select, ready option and polarity
  wire sel = ~drive_select_n;
  wire rdy = spindle_ready & ~recal_q;
  wire opt_ok = (GATE_WITH_READY != 0) ? rdy : 1'b1;
  wire pol = output_polarity_invert;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      track_zero_out <= 1'b0;
      disk_changed_out <= 1'b0;
      drive_ready_out <= 1'b0;
      index_out <= 1'b0;
      read_data_out <= 1'b0;
    end else begin
      track_zero_out <= host_level(tz_q, sel, pol);
      disk_changed_out <= host_level(dc_q, sel, pol);
      drive_ready_out <= host_level(rdy, sel, pol);
      index_out <= host_level(index_in & opt_ok, sel, pol);
      read_data_out <= host_level(read_data_in & opt_ok, sel, pol);
    end
  end

  // ==========================================================
  // apb slave: zero wait states, error on unmapped address
  wire setup = psel & ~penable;
  wire mapped = (paddr == `REG_CTRL) | (paddr == `REG_STATUS);
  wire [31:0] status_w = ({25'h0, trk_q} << `ST_TRACK_LSB) |
    ({31'h0, dir_in_q} << `ST_DIR_BIT) |
    ({31'h0, recal_q} << `ST_RECAL_BIT) |
    ({31'h0, recal_to_q} << `ST_TIMEOUT_BIT) |
    ({31'h0, dc_q} << `ST_CHANGED_BIT) |
    ({30'h0, pos_q} << `ST_POS_LSB) |
    ({31'h0, ~stepper_overdrive_n} << `ST_OVERDRIVE_BIT) |
    ({31'h0, tz_q} << `ST_TZERO_BIT);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (setup) begin
      pready <= 1'b1;
      pslverr <= ~mapped;
      if (pwrite || !mapped) begin
        prdata <= 32'h00000000;
      end else if (paddr == `REG_CTRL) begin
        prdata <= {30'h0, ctrl_q};
      end else begin
        prdata <= status_w;
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule

// *** head_stepper_chk.sv ***
/*
  Port checker for head_stepper_track_control.
  Assumes it is bound into the top module, ports matched by name.
*/
// ==========================================================
// checker
module head_stepper_chk (
  // clock, reset, apb
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [11:0] paddr,
  input wire pready,
  input wire pslverr,
  // straps and select
  input wire low_voltage_ok,
  input wire output_polarity_invert,
  input wire drive_select_n,
  input wire track_zero_sensor,
  // phases and host outputs
  input wire phase_a_drive,
  input wire phase_b_drive,
  input wire phase_a_bar_drive,
  input wire phase_b_bar_drive,
  input wire stepper_overdrive_n,
  input wire track_zero_out,
  input wire disk_changed_out,
  input wire drive_ready_out,
  input wire index_out,
  input wire read_data_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // host output summaries
  wire all_hi = track_zero_out & disk_changed_out & drive_ready_out & index_out & read_data_out;
  wire any_hi = track_zero_out | disk_changed_out | drive_ready_out | index_out | read_data_out;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_apb_rdy;
    psel && penable |-> pready;
  endproperty
  a_apb_rdy: assert property (p_apb_rdy) else $error("access without ready");
  property p_apb_err;
    pslverr |-> pready && paddr != 12'h000 && paddr != 12'h004;
  endproperty
  a_apb_err: assert property (p_apb_err) else $error("error on mapped address");
  property p_od;
    low_voltage_ok && $past(low_voltage_ok) && ($rose(phase_a_drive) || $rose(phase_b_drive)
      || $rose(phase_a_bar_drive) || $rose(phase_b_bar_drive)) |-> !stepper_overdrive_n;
  endproperty
  a_od: assert property (p_od) else $error("phase moved without overdrive");
  property p_overlap;
    low_voltage_ok && $rose(phase_b_drive) |-> (phase_a_drive ^ phase_a_bar_drive) [*4];
  endproperty
  a_overlap: assert property (p_overlap) else $error("old phase dropped early");
  property p_clr;
    !low_voltage_ok ##1 !low_voltage_ok |=> phase_a_drive && !phase_b_drive && stepper_overdrive_n;
  endproperty
  a_clr: assert property (p_clr) else $error("low supply did not clear");
  property p_tz;
    output_polarity_invert && $past(output_polarity_invert) && track_zero_out |->
      $past(!drive_select_n) && $past(track_zero_sensor && phase_a_drive, 2);
  endproperty
  a_tz: assert property (p_tz) else $error("track zero unqualified");
  property p_gate;
    output_polarity_invert && $past(output_polarity_invert && drive_select_n && presetn) |-> !any_hi;
  endproperty
  a_gate: assert property (p_gate) else $error("output while deselected");
  property p_inv;
    !output_polarity_invert && $past(!output_polarity_invert && drive_select_n && presetn) |-> all_hi;
  endproperty
  a_inv: assert property (p_inv) else $error("inverted idle level wrong");
endmodule
bind head_stepper_track_control head_stepper_chk u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .low_voltage_ok(low_voltage_ok),
  .output_polarity_invert(output_polarity_invert), .drive_select_n(drive_select_n),
  .track_zero_sensor(track_zero_sensor), .phase_a_drive(phase_a_drive),
  .phase_b_drive(phase_b_drive), .phase_a_bar_drive(phase_a_bar_drive),
  .phase_b_bar_drive(phase_b_bar_drive), .stepper_overdrive_n(stepper_overdrive_n),
  .track_zero_out(track_zero_out), .disk_changed_out(disk_changed_out),
  .drive_ready_out(drive_ready_out), .index_out(index_out), .read_data_out(read_data_out));

// *** host_fdc_model.sv ***
/*
  Host controller model: step pulses and seek direction.
  Assumes pclk from the bench; steps spaced well apart.
*/
module host_fdc_model (
  // clock
  input wire pclk,
  // step link
  output logic host_step_pulse,
  output logic seek_direction_in,
  output wire change_clear_strobe
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    host_step_pulse = 1'b0;
    seek_direction_in = 1'b0;
  end
  // clear strobe wired to the step line
  assign change_clear_strobe = host_step_pulse;
  // direction set up first, pulse three clocks, then spacing
  task automatic step(input logic dir);
    @(posedge pclk) seek_direction_in <= dir;
    @(posedge pclk) host_step_pulse <= 1'b1;
    repeat (3) @(posedge pclk);
    host_step_pulse <= 1'b0;
    repeat (12) @(posedge pclk);
  endtask
endmodule

// *** head_stepper_track_control_tb.sv ***
/*
  Self-checking bench for head_stepper_track_control, short counts.
  Assumes host_fdc_model drives step and direction.
*/
module head_stepper_track_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // signals
  logic pclk, presetn, psel, penable, pwrite, drive_select_n, density_select, er;
  logic auto_home_enable_n, low_voltage_ok, output_polarity_invert, track_zero_sensor;
  logic disk_present, spindle_ready, index_in, read_data_in;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  wire [31:0] prdata;
  wire pready, pslverr, phase_a_drive, phase_b_drive, phase_a_bar_drive, phase_b_bar_drive;
  wire stepper_overdrive_n, outer_zone_flag, track_zero_out, disk_changed_out;
  wire drive_ready_out, index_out, read_data_out;
  wire host_step_pulse, seek_direction_in, change_clear_strobe;
  wire [3:0] ph = {phase_a_drive, phase_b_drive, phase_a_bar_drive, phase_b_bar_drive};
  int fails = 0;
  int n_tests = 0;
  head_stepper_track_control #(.STEP_DELAY_CYC(24'h14), .OVERLAP_CYC(24'h5),
    .OVERDRIVE_CYC(24'h3C), .RECAL_MAX_CYC(24'h190)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .host_step_pulse(host_step_pulse), .seek_direction_in(seek_direction_in),
    .drive_select_n(drive_select_n), .change_clear_strobe(change_clear_strobe),
    .density_select(density_select), .auto_home_enable_n(auto_home_enable_n),
    .low_voltage_ok(low_voltage_ok), .output_polarity_invert(output_polarity_invert),
    .track_zero_sensor(track_zero_sensor), .disk_present(disk_present),
    .spindle_ready(spindle_ready), .index_in(index_in), .read_data_in(read_data_in),
    .phase_a_drive(phase_a_drive), .phase_b_drive(phase_b_drive),
    .phase_a_bar_drive(phase_a_bar_drive), .phase_b_bar_drive(phase_b_bar_drive),
    .stepper_overdrive_n(stepper_overdrive_n), .outer_zone_flag(outer_zone_flag),
    .track_zero_out(track_zero_out), .disk_changed_out(disk_changed_out),
    .drive_ready_out(drive_ready_out), .index_out(index_out), .read_data_out(read_data_out));
  host_fdc_model u_host (
    .pclk(pclk), .host_step_pulse(host_step_pulse), .seek_direction_in(seek_direction_in),
    .change_clear_strobe(change_clear_strobe));
  // ==========================================================
  // clock and watchdog
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    #1250000;
    fails++;
    close_out;
  end
  // ==========================================================
  // shared tasks
  task automatic close_out;
    $display("fails %0d n_tests %0d", fails, n_tests);
    if (fails == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      fails++;
      close_out;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic st;
    apb(1'b0, 12'h004, 32'h0);
  endtask
  task automatic wait_rdy;
    for (int i = 0; i < 300 && drive_ready_out !== 1'b1; i++) @(posedge pclk);
    chk(drive_ready_out, 1'b1, "ready after recal");
    if (drive_ready_out !== 1'b1) close_out;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_recal;
    low_voltage_ok <= 1'b1;
    cyc(30);
    chk(drive_ready_out, 1'b0, "ready during recal");
    track_zero_sensor <= 1'b1;
    wait_rdy;
    auto_home_enable_n <= 1'b1;
    st;
    chk(rd[13:0], 14'h0, "recal end state");
    chk(track_zero_out, 1'b1, "track zero out");
    $display("recal done");
  endtask
  task automatic t_step;
    density_select <= 1'b1;
    track_zero_sensor <= 1'b0;
    u_host.step(1'b1);
    chk(ph, 4'h4, "phase after step in");
    st;
    chk(rd[13:0], 14'h1101, "step in state");
    u_host.step(1'b0);
    chk(ph, 4'h8, "phase after step out");
    st;
    chk(rd[13:0], 14'h0, "step out state");
    density_select <= 1'b0;
    u_host.step(1'b1);
    chk(ph, 4'h4, "before internal step");
    cyc(25);
    chk(ph, 4'h2, "after internal step");
    st;
    chk(rd[6:0], 7'h02, "double step track");
    u_host.step(1'b0);
    cyc(25);
    chk(ph, 4'h8, "double step back");
    density_select <= 1'b1;
    $display("step done");
  endtask
  task automatic t_od_block;
    u_host.step(1'b1);
    u_host.step(1'b1);
    cyc(40);
    chk(stepper_overdrive_n, 1'b0, "overdrive retriggered");
    cyc(20);
    chk(stepper_overdrive_n, 1'b1, "overdrive expired");
    u_host.step(1'b0);
    u_host.step(1'b0);
    apb(1'b1, 12'h000, 32'h2);
    u_host.step(1'b1);
    st;
    chk(rd[6:0], 7'h00, "blocked step");
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h2, "ctrl readback");
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    chk({er, rd[30:0]}, 32'h80000000, "unmapped read");
    $display("overdrive and block done");
  endtask
  task automatic t_zone;
    for (int i = 1; i <= 44; i++) begin
      u_host.step(1'b1);
      if (i >= 43) chk(outer_zone_flag, i == 43, "zone edge");
    end
    apb(1'b1, 12'h000, 32'h1);
    cyc(410);
    st;
    chk(rd[10:9], 2'h2, "recal timeout");
    track_zero_sensor <= 1'b1;
    apb(1'b1, 12'h000, 32'h1);
    cyc(3);
    wait_rdy;
    st;
    chk({outer_zone_flag, rd[6:0]}, 8'h80, "home after zone");
    track_zero_sensor <= 1'b0;
    u_host.step(1'b1);
    low_voltage_ok <= 1'b0;
    cyc(3);
    chk(ph, 4'h8, "phases cleared");
    st;
    chk(rd[13:0], 14'h0, "state cleared");
    low_voltage_ok <= 1'b1;
    track_zero_sensor <= 1'b1;
    $display("zone and supply done");
  endtask
  task automatic t_disk;
    disk_present <= 1'b0;
    cyc(3);
    chk(disk_changed_out, 1'b1, "change set");
    disk_present <= 1'b1;
    drive_select_n <= 1'b1;
    u_host.step(1'b0);
    chk(disk_changed_out, 1'b0, "deselected gate");
    drive_select_n <= 1'b0;
    output_polarity_invert <= 1'b0;
    cyc(3);
    chk(disk_changed_out, 1'b0, "inverted polarity");
    drive_select_n <= 1'b1;
    cyc(3);
    chk(disk_changed_out, 1'b1, "inverted deselected");
    drive_select_n <= 1'b0;
    output_polarity_invert <= 1'b1;
    u_host.step(1'b0);
    chk(disk_changed_out, 1'b0, "change cleared");
    index_in <= 1'b1;
    read_data_in <= 1'b1;
    cyc(3);
    chk({index_out, read_data_out}, 2'h3, "pass through");
    spindle_ready <= 1'b0;
    cyc(3);
    chk({drive_ready_out, index_out}, 2'h1, "ready follows spindle");
    $display("disk change done");
  endtask
  // ==========================================================
  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    low_voltage_ok = 1'b0;
    index_in = 1'b0;
    read_data_in = 1'b0;
    drive_select_n = 1'b0;
    density_select = 1'b0;
    auto_home_enable_n = 1'b0;
    track_zero_sensor = 1'b0;
    output_polarity_invert = 1'b1;
    disk_present = 1'b1;
    spindle_ready = 1'b1;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_recal;
    t_step;
    t_od_block;
    t_zone;
    t_disk;
    close_out;
  end
endmodule
